// ==== ea_gen_pkg.sv ====
////////////////////////////////////////////////////////////////////////////////
// Shared constants, types and helpers of the effective address generator
////////////////////////////////////////////////////////////////////////////////
package ea_gen_pkg;

	// Word width of every address and register
	localparam int unsigned DATA_W       = 32;
	// Width of the shared displacement and immediate field
	localparam int unsigned FIELD_W      = 12;

	// Post-increment and pre-decrement steps per operand size
	localparam logic [31:0] STEP_BYTE    = 32'h0000_0001;
	localparam logic [31:0] STEP_WORD    = 32'h0000_0002;
	localparam logic [31:0] STEP_LONG    = 32'h0000_0004;

	// Longword PC relative accesses drop the two low PC bits
	localparam logic [31:0] PC_LONG_MASK = 32'hffff_fffc;

	// Value of every data output while idle and after reset
	localparam logic [31:0] RESET_WORD   = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////
	// Enumerations
	////////////////////////////////////////////////////////////////////////////

	// Operand size
	typedef enum logic [1:0] {
		SIZE_BYTE,
		SIZE_WORD,
		SIZE_LONG
	} size_e;

	// Addressing mode or immediate treatment
	typedef enum logic [3:0] {
		MODE_REG_DIRECT,   // Register itself is the operand
		MODE_REG_INDIRECT, // Address is register contents
		MODE_POST_INC,     // Address is register, then register grows
		MODE_PRE_DEC,      // Register shrinks, then is the address
		MODE_REG_DISP4,    // Register plus scaled 4-bit displacement
		MODE_INDEX_R0,     // Register plus index register zero
		MODE_GBR_DISP8,    // Global base plus scaled 8-bit displacement
		MODE_GBR_R0,       // Global base plus index register zero
		MODE_PC_DISP8,     // PC plus scaled 8-bit displacement, data
		MODE_BRANCH8,      // PC plus signed 8-bit displacement times two
		MODE_BRANCH12,     // PC plus signed 12-bit displacement times two
		MODE_PC_REG,       // PC plus register
		MODE_IMM_ZERO,     // Zero-extended immediate, logical group
		MODE_IMM_SIGN,     // Sign-extended immediate, move/add/compare
		MODE_TRAP          // Trap vector offset
	} mode_e;

	////////////////////////////////////////////////////////////////////////////
	// Helpers
	////////////////////////////////////////////////////////////////////////////

	// Step for increment and decrement by operand size
	function automatic logic [31:0] size_step(size_e s);
		case (s)
			SIZE_WORD: size_step = STEP_WORD;
			SIZE_LONG: size_step = STEP_LONG;
			default:   size_step = STEP_BYTE;
		endcase
	endfunction

	// Multiply a zero-extended value by 1, 2 or 4 by operand size
	function automatic logic [31:0] scale_by_size(logic [31:0] v, size_e s);
		case (s)
			SIZE_WORD: scale_by_size = {v[30:0], 1'b0};
			SIZE_LONG: scale_by_size = {v[29:0], 2'b00};
			default:   scale_by_size = v;
		endcase
	endfunction

endpackage

// ==== disp_extender.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Extension and scaling of the displacement or immediate field
////////////////////////////////////////////////////////////////////////////////
module disp_extender
	import ea_gen_pkg::*;
(
	input  wire logic [11:0]       field,
	input  wire ea_gen_pkg::mode_e mode,
	input  wire ea_gen_pkg::size_e size,
	output logic [31:0]            ext_value
);

	// Field pieces by format
	logic [3:0] f4;    // Short displacement
	logic [7:0] f8;    // Byte displacement or immediate

	assign f4 = field[3:0];
	assign f8 = field[7:0];

	////////////////////////////////////////////////////////////////////////////
	// Per-mode extension
	////////////////////////////////////////////////////////////////////////////

	// Pick extension and scale from the mode
	always_comb begin
		case (mode)
			// Zero-extend, scale 1/2/4
			MODE_REG_DISP4: ext_value = scale_by_size({28'h0000000, f4}, size);
			// Zero-extend, scale 1/2/4
			MODE_GBR_DISP8: ext_value = scale_by_size({24'h000000, f8}, size);
			// Zero-extend, scale 4 for longword, else 2
			MODE_PC_DISP8: begin
				if (size == SIZE_LONG) begin
					ext_value = {22'h000000, f8, 2'b00};
				end else begin
					ext_value = {23'h000000, f8, 1'b0};
				end
			end
			// Sign-extend, times two
			MODE_BRANCH8:  ext_value = {{23{f8[7]}}, f8, 1'b0};
			// Sign-extend, times two
			MODE_BRANCH12: ext_value = {{19{field[11]}}, field, 1'b0};
			// Zero-extend for logical group
			MODE_IMM_ZERO: ext_value = {24'h000000, f8};
			// Sign-extend for move, add, compare
			MODE_IMM_SIGN: ext_value = {{24{f8[7]}}, f8};
			// Zero-extend, times four
			MODE_TRAP:     ext_value = {22'h000000, f8, 2'b00};
			// Modes with no displacement
			default:       ext_value = RESET_WORD;
		endcase
	end

endmodule // disp_extender

// ==== effective_address_generator.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Effective address generator, one request per cycle, one cycle latency
////////////////////////////////////////////////////////////////////////////////
module effective_address_generator
	import ea_gen_pkg::*;
(
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire logic                req_valid,
	input  wire ea_gen_pkg::mode_e   req_mode,
	input  wire ea_gen_pkg::size_e   req_size,
	input  wire logic [11:0]         req_field,
	input  wire logic [31:0]         selected_general_register,
	input  wire logic [31:0]         index_register_zero,
	input  wire logic [31:0]         global_base_register,
	input  wire logic [31:0]         program_counter,
	output logic                     result_valid,
	output logic                     address_valid,
	output logic                     operand_valid,
	output logic [31:0]              address,
	output logic [31:0]              operand,
	output logic                     writeback_en,
	output logic [31:0]              writeback_value
);

	////////////////////////////////////////////////////////////////////////////
	// State
	////////////////////////////////////////////////////////////////////////////

	// All registered results
	typedef struct packed {
		logic        valid;      // Result present this cycle
		logic        addr_valid; // Address field meaningful
		logic        opnd_valid; // Operand field meaningful
		logic        wb_en;      // Register update requested
		logic [31:0] addr;       // Effective address or target
		logic [31:0] opnd;       // Register or immediate operand
		logic [31:0] wb_value;   // Value for register update
	} state_s;

	// Idle state, also the reset value
	localparam state_s STATE_IDLE = '{
		valid:      1'b0,
		addr_valid: 1'b0,
		opnd_valid: 1'b0,
		wb_en:      1'b0,
		addr:       RESET_WORD,
		opnd:       RESET_WORD,
		wb_value:   RESET_WORD
	};

	state_s      state_r;    // Registered state
	state_s      state_nxt;  // Next state
	logic [31:0] ext_value;  // Extended and scaled field
	logic [31:0] step;       // Increment or decrement step
	logic [31:0] pc_base;    // PC, masked for longword data

	////////////////////////////////////////////////////////////////////////////
	// Field extension
	////////////////////////////////////////////////////////////////////////////

	// Displacement and immediate extender
	disp_extender u_disp_extender (
		.field     (req_field),
		.mode      (req_mode),
		.size      (req_size),
		.ext_value (ext_value)
	);

	// Step by operand size
	assign step = size_step(req_size);

	// Longword data masks the PC, word data does not
	assign pc_base = (req_size == SIZE_LONG) ? (program_counter & PC_LONG_MASK)
	                                         : program_counter;

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	////////////////////////////////////////////////////////////////////////////

	// Compute one result per accepted request; sums are 32 bits and wrap
	always_comb begin
		state_nxt = STATE_IDLE;
		if (req_valid) begin
			state_nxt.valid = 1'b1;
			case (req_mode)
				// Operand is the register itself
				MODE_REG_DIRECT: begin
					state_nxt.opnd_valid = 1'b1;
					state_nxt.opnd       = selected_general_register;
				end
				// Register is the address
				MODE_REG_INDIRECT: begin
					state_nxt.addr_valid = 1'b1;
					state_nxt.addr       = selected_general_register;
				end
				// Old value addresses, grown value written back
				MODE_POST_INC: begin
					state_nxt.addr_valid = 1'b1;
					state_nxt.addr       = selected_general_register;
					state_nxt.wb_en      = 1'b1;
					state_nxt.wb_value   = selected_general_register + step;
				end
				// Shrunk value both addresses and is written back
				MODE_PRE_DEC: begin
					state_nxt.addr_valid = 1'b1;
					state_nxt.addr       = selected_general_register - step;
					state_nxt.wb_en      = 1'b1;
					state_nxt.wb_value   = selected_general_register - step;
				end
				// Register plus scaled short displacement
				MODE_REG_DISP4: begin
					state_nxt.addr_valid = 1'b1;
					state_nxt.addr       = selected_general_register + ext_value;
				end
				// Register plus index register zero
				MODE_INDEX_R0: begin
					state_nxt.addr_valid = 1'b1;
					state_nxt.addr       = selected_general_register + index_register_zero;
				end
				// Global base plus scaled displacement
				MODE_GBR_DISP8: begin
					state_nxt.addr_valid = 1'b1;
					state_nxt.addr       = global_base_register + ext_value;
				end
				// Global base plus index register zero
				MODE_GBR_R0: begin
					state_nxt.addr_valid = 1'b1;
					state_nxt.addr       = global_base_register + index_register_zero;
				end
				// PC data access
				MODE_PC_DISP8: begin
					state_nxt.addr_valid = 1'b1;
					state_nxt.addr       = pc_base + ext_value;
				end
				// Short and long branch targets
				MODE_BRANCH8, MODE_BRANCH12: begin
					state_nxt.addr_valid = 1'b1;
					state_nxt.addr       = program_counter + ext_value;
				end
				// Register-relative branch target
				MODE_PC_REG: begin
					state_nxt.addr_valid = 1'b1;
					state_nxt.addr       = program_counter + selected_general_register;
				end
				// Immediates and trap offset leave on the operand
				MODE_IMM_ZERO, MODE_IMM_SIGN, MODE_TRAP: begin
					state_nxt.opnd_valid = 1'b1;
					state_nxt.opnd       = ext_value;
				end
				// Unknown code gives an empty result
				default: begin
					state_nxt.valid = 1'b1;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r <= STATE_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Outputs straight from the state register
	assign result_valid    = state_r.valid;
	assign address_valid   = state_r.addr_valid;
	assign operand_valid   = state_r.opnd_valid;
	assign address         = state_r.addr;
	assign operand         = state_r.opnd;
	assign writeback_en    = state_r.wb_en;
	assign writeback_value = state_r.wb_value;

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	////////////////////////////////////////////////////////////////////////////

	// Shared clock and reset
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// Register direct gives the register as operand, no address
	a_direct_operand: assert property (
		(req_valid && req_mode == MODE_REG_DIRECT) |=>
		(operand_valid && !address_valid && !writeback_en &&
		 operand == $past(selected_general_register))
	) else $error("register direct operand wrong");

	// Register indirect passes register unchanged
	a_indirect_addr: assert property (
		(req_valid && req_mode == MODE_REG_INDIRECT) |=>
		(address_valid && !writeback_en && address == $past(selected_general_register))
	) else $error("register indirect address wrong");

	// Post-increment uses old value and writes it plus step
	a_post_inc_update: assert property (
		(req_valid && req_mode == MODE_POST_INC) |=>
		(address == $past(selected_general_register) && writeback_en &&
		 writeback_value - address == size_step($past(req_size)))
	) else $error("post-increment update wrong");

	// Word pre-decrement uses and writes back the decremented value
	a_pre_dec_update: assert property (
		(req_valid && req_mode == MODE_PRE_DEC && req_size == SIZE_WORD) |=>
		(writeback_en && address == writeback_value &&
		 address == $past(selected_general_register) - STEP_WORD)
	) else $error("pre-decrement update wrong");

	// Short displacement scaled by four for longword
	a_disp4_long: assert property (
		(req_valid && req_mode == MODE_REG_DISP4 && req_size == SIZE_LONG) |=>
		(address == $past(selected_general_register) + {26'h0, $past(req_field[3:0]), 2'b00})
	) else $error("short displacement address wrong");

	// Index mode sum
	a_index_sum: assert property (
		(req_valid && req_mode == MODE_INDEX_R0) |=>
		(address == $past(selected_general_register) + $past(index_register_zero))
	) else $error("index register address wrong");

	// Global base displacement scaled by two for word
	a_gbr_disp_word: assert property (
		(req_valid && req_mode == MODE_GBR_DISP8 && req_size == SIZE_WORD) |=>
		(address == $past(global_base_register) + {23'h0, $past(req_field[7:0]), 1'b0})
	) else $error("global base displacement wrong");

	// Global base plus index register zero
	a_gbr_index_sum: assert property (
		(req_valid && req_mode == MODE_GBR_R0) |=>
		(address == $past(global_base_register) + $past(index_register_zero))
	) else $error("global base index address wrong");

	// Word PC data uses the raw PC
	a_pc_word_data: assert property (
		(req_valid && req_mode == MODE_PC_DISP8 && req_size == SIZE_WORD) |=>
		(address == $past(program_counter) + {23'h0, $past(req_field[7:0]), 1'b0})
	) else $error("word PC relative address wrong");

	// Longword PC data masks the low PC bits
	a_pc_long_mask: assert property (
		(req_valid && req_mode == MODE_PC_DISP8 && req_size == SIZE_LONG) |=>
		(address == ($past(program_counter) & PC_LONG_MASK) +
		            {22'h0, $past(req_field[7:0]), 2'b00})
	) else $error("longword PC relative address wrong");

	// Short branch, negative displacement reaches backwards
	a_branch8_target: assert property (
		(req_valid && req_mode == MODE_BRANCH8) |=>
		(address == $past(program_counter) + {{23{$past(req_field[7])}}, $past(req_field[7:0]), 1'b0})
	) else $error("short branch target wrong");

	// Long branch target
	a_branch12_target: assert property (
		(req_valid && req_mode == MODE_BRANCH12) |=>
		(address == $past(program_counter) + {{19{$past(req_field[11])}}, $past(req_field), 1'b0})
	) else $error("long branch target wrong");

	// Register-relative branch target
	a_pc_reg_target: assert property (
		(req_valid && req_mode == MODE_PC_REG) |=>
		(address == $past(program_counter) + $past(selected_general_register))
	) else $error("register branch target wrong");

	// Logical group immediate clears upper bits
	a_imm_zero_ext: assert property (
		(req_valid && req_mode == MODE_IMM_ZERO) |=>
		(operand_valid && operand[31:8] == 24'h000000 && operand[7:0] == $past(req_field[7:0]))
	) else $error("zero-extended immediate wrong");

	// Arithmetic immediate copies the sign bit upward
	a_imm_sign_ext: assert property (
		(req_valid && req_mode == MODE_IMM_SIGN) |=>
		(operand_valid && $signed(operand) == $signed($past(req_field[7:0])))
	) else $error("sign-extended immediate wrong");

	// Trap offset is immediate times four
	a_trap_offset: assert property (
		(req_valid && req_mode == MODE_TRAP) |=>
		(operand_valid && operand == {22'h0, $past(req_field[7:0]), 2'b00})
	) else $error("trap vector offset wrong");

	// Longword post-increment near the top wraps to the low bits
	a_wrap_around: assert property (
		(req_valid && req_mode == MODE_POST_INC && req_size == SIZE_LONG &&
		 selected_general_register[31:2] == 30'h3fff_ffff) |=>
		(writeback_en && writeback_value == {30'h0, $past(selected_general_register[1:0])})
	) else $error("32-bit wrap wrong");

	// Byte pre-decrement steps down by one
	a_pre_dec_byte: assert property (
		(req_valid && req_mode == MODE_PRE_DEC && req_size == SIZE_BYTE) |=>
		(writeback_en && address_valid && writeback_value == address &&
		 address == $past(selected_general_register) - STEP_BYTE)
	) else $error("byte pre-decrement wrong");

	// Byte short displacement is not scaled
	a_disp4_byte: assert property (
		(req_valid && req_mode == MODE_REG_DISP4 && req_size == SIZE_BYTE) |=>
		(address_valid && address == $past(selected_general_register) + {28'h0, $past(req_field[3:0])})
	) else $error("byte short displacement wrong");

	// Global base displacement scaled by four for longword
	a_gbr_disp_long: assert property (
		(req_valid && req_mode == MODE_GBR_DISP8 && req_size == SIZE_LONG) |=>
		(address == $past(global_base_register) + {22'h0, $past(req_field[7:0]), 2'b00})
	) else $error("longword global base displacement wrong");

	// Without a result every output rests at zero
	a_idle_quiet: assert property (
		!result_valid |-> (!address_valid && !operand_valid && !writeback_en &&
		 address == RESET_WORD && operand == RESET_WORD && writeback_value == RESET_WORD)
	) else $error("idle outputs not zero");

	// Only the stepping modes update a register
	a_no_stray_wb: assert property (
		(req_valid && req_mode != MODE_POST_INC && req_mode != MODE_PRE_DEC) |=>
		!writeback_en
	) else $error("stray register update");

	// Result pulse follows each taken request and nothing else
	a_one_cycle_latency: assert property (
		result_valid == ($past(req_valid) && !$past(rst))
	) else $error("result timing wrong");

endmodule // effective_address_generator

// ==== tb_effective_address_generator.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the effective address generator
////////////////////////////////////////////////////////////////////////////////
`define CHK(name, exp, got) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		err_total++; \
		$display("wrong value %s expected %h seen %h", name, exp, got); \
	end \
end

module tb_effective_address_generator;
	import ea_gen_pkg::*;

	// Expected outputs of one cycle
	typedef struct packed {
		logic        rv;
		logic        av;
		logic [31:0] ad;
		logic        ov;
		logic [31:0] op;
		logic        wb;
		logic [31:0] wv;
	} result_s;

	// Kinds of expected answer
	localparam int K_ADDR = 0;
	localparam int K_OPND = 1;
	localparam int K_WB   = 2;
	localparam int K_NONE = 3;

	logic        ref_clk;                   // Core clock
	logic        rst;                       // Synchronous reset
	logic        req_valid;                 // Request strobe
	mode_e       req_mode;                  // Mode of request
	size_e       req_size;                  // Operand size
	logic [11:0] req_field;                 // Displacement or immediate
	logic [31:0] selected_general_register; // Named register
	logic [31:0] index_register_zero;       // Index register
	logic [31:0] global_base_register;      // Global base
	logic [31:0] program_counter;           // Program counter
	logic        result_valid;              // Result strobe
	logic        address_valid;             // Address qualifier
	logic        operand_valid;             // Operand qualifier
	logic [31:0] address;                   // Effective address
	logic [31:0] operand;                   // Operand value
	logic        writeback_en;              // Register update strobe
	logic [31:0] writeback_value;           // Register update value
	int          err_total;                 // Mismatches seen
	int          n_tests;                   // Comparisons made
	int          cyc;                       // Cycles since start
	result_s     exp_q[$];                  // Answers still due
	result_s     e;                         // Answer of this cycle
	logic        taken;                     // Request taken at this edge
	logic        live;                      // Out of reset at this edge

	effective_address_generator dut_u (
		.ref_clk                   (ref_clk),
		.rst                       (rst),
		.req_valid                 (req_valid),
		.req_mode                  (req_mode),
		.req_size                  (req_size),
		.req_field                 (req_field),
		.selected_general_register (selected_general_register),
		.index_register_zero       (index_register_zero),
		.global_base_register      (global_base_register),
		.program_counter           (program_counter),
		.result_valid              (result_valid),
		.address_valid             (address_valid),
		.operand_valid             (operand_valid),
		.address                   (address),
		.operand                   (operand),
		.writeback_en              (writeback_en),
		.writeback_value           (writeback_value)
	);

	////////////////////////////////////////////////////////////////////////////
	// Clock, watchdog and verdict
	////////////////////////////////////////////////////////////////////////////

	// Free running 100 MHz clock
	always #5 ref_clk = ~ref_clk;

	// Ends the run with counts and verdict
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Monitor: each output stands one cycle after its request, else zero
	////////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk) begin
		taken = (req_valid === 1'b1) && (rst === 1'b0);
		live = (rst === 1'b0);
		#1;
		if (live) begin
			e = '0;
			if (taken) begin
				e = exp_q.pop_front();
			end
			`CHK("result_valid", e.rv, result_valid)
			`CHK("address_valid", e.av, address_valid)
			`CHK("address", e.ad, address)
			`CHK("operand_valid", e.ov, operand_valid)
			`CHK("operand", e.op, operand)
			`CHK("writeback_en", e.wb, writeback_en)
			`CHK("writeback_value", e.wv, writeback_value)
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Drivers
	////////////////////////////////////////////////////////////////////////////

	// Data register inputs, at the edge
	task automatic set_regs(input logic [31:0] rg, input logic [31:0] r0,
			input logic [31:0] gb, input logic [31:0] pc);
		selected_general_register <= rg;
		index_register_zero       <= r0;
		global_base_register      <= gb;
		program_counter           <= pc;
	endtask

	// One request, its answer queued for the monitor
	task automatic drive(input mode_e m, input int sz, input logic [11:0] f,
			input int kind, input logic [31:0] v, input logic [31:0] wv);
		result_s x;
		x = '0;
		x.rv = 1'b1;
		case (kind)
			K_ADDR: begin
				x.av = 1'b1;
				x.ad = v;
			end
			K_OPND: begin
				x.ov = 1'b1;
				x.op = v;
			end
			K_WB: begin
				x.av = 1'b1;
				x.ad = v;
				x.wb = 1'b1;
				x.wv = wv;
			end
			default: ;
		endcase
		exp_q.push_back(x);
		req_valid <= 1'b1;
		req_mode  <= m;
		req_size  <= size_e'(sz);
		req_field <= f;
		@(posedge ref_clk);
	endtask

	// Drops the strobe and lets one idle cycle be judged
	task automatic finish_seq();
		req_valid <= 1'b0;
		@(posedge ref_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	////////////////////////////////////////////////////////////////////////////

	// Register itself, then register as pointer, back to back
	task automatic t_direct();
		set_regs(32'hdead_beef, 32'h1, 32'h2, 32'h3);
		drive(MODE_REG_DIRECT, 2, 12'h000, K_OPND, 32'hdead_beef, '0);
		drive(MODE_REG_INDIRECT, 0, 12'hfff, K_ADDR, 32'hdead_beef, '0);
		finish_seq();
	endtask

	// Increments and decrements of every size near the wrap point; word and longword increments and the longword decrement wrap
	task automatic t_step();
		logic [31:0] v;
		for (int i = 0; i < 3; i++) begin
			set_regs(32'hffff_fffe, 32'h0, 32'h0, 32'h0);
			v = 32'hffff_fffe + (32'h1 << i);
			drive(MODE_POST_INC, i, 12'h000, K_WB, 32'hffff_fffe, v);
		end
		for (int i = 0; i < 3; i++) begin
			set_regs(32'h0000_0002, 32'h0, 32'h0, 32'h0);
			v = 32'h0000_0002 - (32'h1 << i);
			drive(MODE_PRE_DEC, i, 12'h000, K_WB, v, v);
		end
		finish_seq();
	endtask

	// Scaled short and byte displacements; upper field bits ignored
	task automatic t_disp();
		for (int i = 0; i < 3; i++) begin
			set_regs(32'h0000_1000, 32'h0, 32'h0000_2000, 32'h0);
			drive(MODE_REG_DISP4, i, 12'hff5, K_ADDR, 32'h1000 + (32'h5 << i), '0);
			set_regs(32'h0000_1000, 32'h0, 32'h0000_2000, 32'h0);
			drive(MODE_GBR_DISP8, i, 12'hfa5, K_ADDR, 32'h2000 + (32'ha5 << i), '0);
		end
		finish_seq();
	endtask

	// Register sums, two of them wrapping
	task automatic t_sums();
		set_regs(32'hf000_0000, 32'h2000_0010, 32'h0000_1000, 32'h8000_0000);
		drive(MODE_INDEX_R0, 1, 12'h000, K_ADDR, 32'h1000_0010, '0);
		drive(MODE_GBR_R0, 2, 12'h000, K_ADDR, 32'h2000_1010, '0);
		drive(MODE_PC_REG, 0, 12'h000, K_ADDR, 32'h7000_0000, '0);
		finish_seq();
	endtask

	// PC relative data and branches with boundary displacements
	task automatic t_pc_rel();
		set_regs(32'h0, 32'h0, 32'h0, 32'h0000_1003);
		drive(MODE_PC_DISP8, 1, 12'hf80, K_ADDR, 32'h0000_1103, '0);
		drive(MODE_PC_DISP8, 0, 12'h001, K_ADDR, 32'h0000_1005, '0);
		drive(MODE_PC_DISP8, 2, 12'hf80, K_ADDR, 32'h0000_1200, '0);
		drive(MODE_BRANCH8, 2, 12'hfff, K_ADDR, 32'h0000_1001, '0);
		drive(MODE_BRANCH8, 2, 12'h07f, K_ADDR, 32'h0000_1101, '0);
		drive(MODE_BRANCH12, 2, 12'h800, K_ADDR, 32'h0000_0003, '0);
		drive(MODE_BRANCH12, 2, 12'h7ff, K_ADDR, 32'h0000_2001, '0);
		finish_seq();
	endtask

	// Immediate extension, trap offset and an unknown mode code
	task automatic t_imm();
		set_regs(32'h5555_5555, 32'h0, 32'h0, 32'h0);
		drive(MODE_IMM_ZERO, 2, 12'hf80, K_OPND, 32'h0000_0080, '0);
		drive(MODE_IMM_SIGN, 2, 12'hf80, K_OPND, 32'hffff_ff80, '0);
		drive(MODE_IMM_SIGN, 2, 12'h07f, K_OPND, 32'h0000_007f, '0);
		drive(MODE_TRAP, 2, 12'hfff, K_OPND, 32'h0000_03fc, '0);
		drive(mode_e'(4'hf), 2, 12'hfff, K_NONE, '0, '0);
		finish_seq();
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		req_valid = 1'b0;
		req_mode = MODE_REG_DIRECT;
		req_size = SIZE_BYTE;
		req_field = 12'h000;
		selected_general_register = 32'h0;
		index_register_zero = 32'h0;
		global_base_register = 32'h0;
		program_counter = 32'h0;
		err_total = 0;
		n_tests = 0;
		cyc = 0;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_direct();
		t_step();
		t_disp();
		t_sums();
		t_pc_rel();
		t_imm();
		repeat (2) @(posedge ref_clk);
		give_verdict();
	end

endmodule // tb_effective_address_generator
